// ### rtl/pscs_pkg.sv
package pscs_pkg;

	// ======================================================================
	// Timing
	// ======================================================================
	localparam int CLK_MHZ = 100;
	localparam int REF_MHZ = 5;
	localparam int REF_DIV = CLK_MHZ / REF_MHZ;
	localparam int REF_PERIOD_NS = 1000 / REF_MHZ;
	localparam int SLOW_KHZ = 300;
	localparam int MON_WIN_REF = 50;
	localparam int MON_MIN_EDGES =
		MON_WIN_REF * REF_PERIOD_NS * SLOW_KHZ / 1000000;
	localparam int LOCK_NS = 1000;
	localparam int LOCK_CYC = LOCK_NS * CLK_MHZ / 1000;
	localparam int SYS_MAX_MHZ = 40;
	localparam int SYS_MIN_CYC = (CLK_MHZ + SYS_MAX_MHZ - 1) / SYS_MAX_MHZ;

	// ======================================================================
	// Register offsets
	// ======================================================================
	localparam logic [7:0] ADDR_OSC = 8'h00;
	localparam logic [7:0] ADDR_SYN = 8'h01;
	localparam logic [7:0] ADDR_FBDIV = 8'h02;
	localparam logic [7:0] ADDR_SYS = 8'h03;
	localparam logic [7:0] ADDR_PMC = 8'h04;
	localparam logic [7:0] ADDR_TEN = 8'h05;
	localparam logic [7:0] ADDR_TST = 8'h06;

	// ======================================================================
	// Field positions
	// ======================================================================
	localparam int OSC_SEL_LSB = 0;
	localparam int OSC_RST_BIT = 2;
	localparam int OSC_SLOW_BIT = 3;
	localparam int SYN_LOCK_BIT = 0;
	localparam int SYN_RESTART_STABILITY_DETECT_BIT = 1;
	localparam int SYN_BYP_BIT = 2;
	localparam int SYN_VCO_BIT = 3;
	localparam int SYN_FREE_BIT = 4;
	localparam int SYN_K_LSB = 5;
	localparam int SYS_SRC_LSB = 0;
	localparam int SYS_FAC_LSB = 2;
	localparam int PMC_SD_BIT = 0;
	localparam int PMC_DIV_LSB = 1;
	localparam int TRP_MON_BIT = 0;
	localparam int TRP_LOCK_BIT = 1;

	// ======================================================================
	// Reset values
	// ======================================================================
	localparam logic [1:0] RST_INSEL = 2'h0;
	localparam logic [7:0] RST_FBDIV = 8'h10;
	localparam logic [2:0] RST_OUTPUT_DIVIDER_VALUE = 3'h2;
	localparam logic RST_BYP = 1'b0;
	localparam logic RST_VCO = 1'b0;
	localparam logic [1:0] RST_FAC = 2'h0;
	localparam logic [2:0] RST_SDDIV = 3'h0;
	localparam logic [1:0] INSEL_XTAL = 2'h1;

	// ======================================================================
	// Types
	// ======================================================================
	typedef enum logic [1:0] {
		PSCS_SRC_LP = 2'h0,
		PSCS_SRC_PLL = 2'h1,
		PSCS_SRC_OSC = 2'h2
	} pscs_src_t;

	typedef enum logic {ST_BOOT, ST_RUN} pscs_start_t;

	typedef struct packed {
		logic [1:0] pll_input_select;
		logic [7:0] feedback_divider;
		logic vco_range_select;
		logic [2:0] output_divider_value;
		logic vco_bypass_select;
		logic freerun;
	} pscs_pll_cfg_t;

	typedef struct packed {
		logic sys;
		logic nvm_access;
		logic cpu;
		logic periph_a;
		logic periph_b;
		logic nvm_bus;
	} pscs_clk_en_t;

endpackage

// ### rtl/pscs_top.sv
// Contract
// - Reference oscillator runs at nominal 5 MHz.
// - Internal oscillator selectable as PLL input always.
// - Too slow crystal sets too-slow flag.
// - Monitor trap only in two source cases.
// - Unused or bypassed PLL: lock loss clears stable.
// - Used PLL lock loss sets trap flag.
// - No lock trap before first stable.
// - Monitor event (bypass, crystal input) or lock event (no bypass) forces freerun until bypass.
// - System clock from exactly one of three.
// - Derived clocks equal CPU, at most 40 MHz.
// - Wake: peripheral b early, a after lock.
// - Factor field sets NVM to CPU ratio.
// - Slowdown divider only when enabled, divides NVM.
// - Boot on low precision clock, then PLL.
// - No lock at startup keeps low precision.
// - Watchdog and soft reset keep configuration.
// - Monitor flags crystal below 300 kHz only.
// - Monitor restart, status valid after reference cycles.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
module pscs_top
	import pscs_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic osc_in,
	input wire logic pll_tick,
	input wire logic lp_tick,
	input wire logic pll_match,
	input wire logic power_down,
	output pscs_pll_cfg_t pll_cfg,
	output pscs_clk_en_t clk_en,
	output logic sysclk_source_q,
	output logic mon_trap_req,
	output logic lock_trap_req
);

	// ======================================================================
	// Register decode
	// ======================================================================
	wire wr_osc = reg_wr && (reg_addr == ADDR_OSC);
	wire wr_syn = reg_wr && (reg_addr == ADDR_SYN);
	wire wr_fbd = reg_wr && (reg_addr == ADDR_FBDIV);
	wire wr_sys = reg_wr && (reg_addr == ADDR_SYS);
	wire wr_pmc = reg_wr && (reg_addr == ADDR_PMC);
	wire wr_ten = reg_wr && (reg_addr == ADDR_TEN);
	wire wr_tst = reg_wr && (reg_addr == ADDR_TST);
	wire mon_restart = wr_osc && reg_wdata[OSC_RST_BIT];
	wire restart_stability_detect = wr_syn && reg_wdata[SYN_RESTART_STABILITY_DETECT_BIT];
	wire byp_wr1 = wr_syn && reg_wdata[SYN_BYP_BIT];

	// Configuration is cleared only by nrst; watchdog and soft resets are
	// not wired here so the clock setup survives them.
	logic [1:0] insel_q;
	logic [7:0] fbdiv_q;
	logic [2:0] output_divider_value_q;
	logic byp_q, vco_q, sd_en_q, mon_en_q, lock_en_q;
	logic [1:0] fac_q, src_q;
	logic [2:0] sd_div_q;
	logic too_slow_q, stable_q, ever_locked_q, freerun_q;
	logic mon_flag_q, lock_flag_q;
	pscs_start_t st_q;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			insel_q <= RST_INSEL;
			fbdiv_q <= RST_FBDIV;
			output_divider_value_q <= RST_OUTPUT_DIVIDER_VALUE;
			byp_q <= RST_BYP;
			vco_q <= RST_VCO;
			fac_q <= RST_FAC;
			sd_div_q <= RST_SDDIV;
			sd_en_q <= 1'b0;
			mon_en_q <= 1'b0;
			lock_en_q <= 1'b0;
		end else begin
			// Any input select is legal in every mode, the internal one too.
			if (wr_osc) insel_q <= reg_wdata[OSC_SEL_LSB +: 2];
			if (wr_syn) begin
				byp_q <= reg_wdata[SYN_BYP_BIT];
				vco_q <= reg_wdata[SYN_VCO_BIT];
				output_divider_value_q <= reg_wdata[SYN_K_LSB +: 3];
			end
			if (wr_fbd) fbdiv_q <= reg_wdata;
			if (wr_sys) fac_q <= reg_wdata[SYS_FAC_LSB +: 2];
			if (wr_pmc) begin
				sd_en_q <= reg_wdata[PMC_SD_BIT];
				sd_div_q <= reg_wdata[PMC_DIV_LSB +: 3];
			end
			if (wr_ten) begin
				mon_en_q <= reg_wdata[TRP_MON_BIT];
				lock_en_q <= reg_wdata[TRP_LOCK_BIT];
			end
		end
	end

	// ======================================================================
	// Reference oscillator and crystal monitor
	// ======================================================================
	logic [4:0] ref_cnt_q;
	logic [5:0] win_cnt_q;
	logic [7:0] edge_cnt_q;
	logic osc_q;
	wire ref_tick = (ref_cnt_q == 5'(REF_DIV - 1));
	wire win_end = ref_tick && (win_cnt_q == 6'(MON_WIN_REF - 1));
	wire osc_rise = osc_in && !osc_q;
	wire slow_now = edge_cnt_q < 8'(MON_MIN_EDGES);
	wire slow_rise = win_end && slow_now && !too_slow_q && !mon_restart;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ref_cnt_q <= 5'h00;
			win_cnt_q <= 6'h00;
			edge_cnt_q <= 8'h00;
			osc_q <= 1'b0;
			too_slow_q <= 1'b0;
		end else begin
			osc_q <= osc_in;
			ref_cnt_q <= ref_tick ? 5'h00 : ref_cnt_q + 5'h01;
			// A restart throws away the running window, so the flag is only
			// judged again after a full window of reference cycles.
			if (mon_restart) begin
				win_cnt_q <= 6'h00;
				edge_cnt_q <= 8'h00;
				too_slow_q <= 1'b0;
			end else if (win_end) begin
				win_cnt_q <= 6'h00;
				edge_cnt_q <= 8'h00;
				too_slow_q <= slow_now;
			end else begin
				if (ref_tick) win_cnt_q <= win_cnt_q + 6'h01;
				if (osc_rise && edge_cnt_q != 8'hff)
					edge_cnt_q <= edge_cnt_q + 8'h01;
			end
		end
	end

	// ======================================================================
	// Lock detector, traps and freerun
	// ======================================================================
	logic [7:0] lock_cnt_q;
	wire pll_used = (src_q == PSCS_SRC_PLL) && !byp_q;
	wire lock_loss = stable_q && !pll_match && !restart_stability_detect;
	wire lock_hit = !stable_q && (lock_cnt_q == 8'(LOCK_CYC - 1));
	wire mon_case = (byp_q && insel_q == INSEL_XTAL &&
		src_q == PSCS_SRC_PLL) || (src_q == PSCS_SRC_OSC);
	wire mon_set = slow_rise && mon_case;
	// A lock trap needs a lock seen before, so power-on is quiet.
	wire lock_set = lock_loss && pll_used && ever_locked_q;
	wire fr_set = (slow_rise && byp_q && insel_q == INSEL_XTAL) ||
		(lock_loss && !byp_q);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			lock_cnt_q <= 8'h00;
			stable_q <= 1'b0;
			ever_locked_q <= 1'b0;
			freerun_q <= 1'b0;
			mon_flag_q <= 1'b0;
			lock_flag_q <= 1'b0;
		end else begin
			if (restart_stability_detect || lock_loss) begin
				stable_q <= 1'b0;
				lock_cnt_q <= 8'h00;
			end else if (!stable_q) begin
				lock_cnt_q <= pll_match ? lock_cnt_q + 8'h01 : 8'h00;
				if (lock_hit && pll_match) begin
					stable_q <= 1'b1;
					ever_locked_q <= 1'b1;
				end
			end
			// Freerun holds until bypass is written again; set wins.
			if (fr_set) freerun_q <= 1'b1;
			else if (byp_wr1) freerun_q <= 1'b0;
			// Write one clears a flag; a same-cycle event still sets it.
			if (mon_set) mon_flag_q <= 1'b1;
			else if (wr_tst && reg_wdata[TRP_MON_BIT]) mon_flag_q <= 1'b0;
			if (lock_set) lock_flag_q <= 1'b1;
			else if (wr_tst && reg_wdata[TRP_LOCK_BIT]) lock_flag_q <= 1'b0;
		end
	end

	assign mon_trap_req = mon_flag_q && mon_en_q;
	assign lock_trap_req = lock_flag_q && lock_en_q;

	// ======================================================================
	// Startup source control
	// ======================================================================
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st_q <= ST_BOOT;
			src_q <= PSCS_SRC_LP;
		end else begin
			unique case (st_q)
				// Without a lock the low precision clock stays on.
				ST_BOOT: begin
					if (stable_q) begin
						st_q <= ST_RUN;
						src_q <= PSCS_SRC_PLL;
					end
				end
				ST_RUN: begin
					if (wr_sys) src_q <= reg_wdata[SYS_SRC_LSB +: 2];
				end
			endcase
		end
	end
	assign sysclk_source_q = (src_q == PSCS_SRC_PLL);

	// ======================================================================
	// Clock derivation
	// ======================================================================
	logic [1:0] gap_q;
	logic [2:0] sd_cnt_q;
	logic [1:0] fac_cnt_q;
	logic pa_hold_q;
	// Codes other than the three sources fall back to the slow clock.
	wire src_edge = (src_q == PSCS_SRC_PLL) ? pll_tick :
		(src_q == PSCS_SRC_OSC) ? osc_rise : lp_tick;
	// Edges closer than the 40 MHz period are dropped, not queued.
	wire sys_tick = src_edge && (gap_q >= 2'(SYS_MIN_CYC - 1));
	wire [2:0] sd_lim = sd_en_q ? sd_div_q : 3'h0;
	wire nvm_tick = sys_tick && (sd_cnt_q >= sd_lim);
	wire cpu_tick = nvm_tick && (fac_cnt_q >= fac_q);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			gap_q <= 2'(SYS_MIN_CYC - 1);
			sd_cnt_q <= 3'h0;
			fac_cnt_q <= 2'h0;
			pa_hold_q <= 1'b0;
		end else begin
			if (sys_tick) gap_q <= 2'h0;
			else if (gap_q != 2'(SYS_MIN_CYC - 1)) gap_q <= gap_q + 2'h1;
			if (sys_tick)
				sd_cnt_q <= (sd_cnt_q >= sd_lim) ? 3'h0 : sd_cnt_q + 3'h1;
			if (nvm_tick)
				fac_cnt_q <= (fac_cnt_q >= fac_q) ? 2'h0 : fac_cnt_q + 2'h1;
			if (power_down) pa_hold_q <= 1'b1;
			else if (stable_q) pa_hold_q <= 1'b0;
		end
	end

	assign clk_en.sys = sys_tick;
	assign clk_en.nvm_access = nvm_tick;
	assign clk_en.cpu = cpu_tick;
	assign clk_en.periph_b = cpu_tick && !power_down;
	assign clk_en.nvm_bus = cpu_tick && !power_down;
	assign clk_en.periph_a = cpu_tick && !power_down && !pa_hold_q;

	assign pll_cfg.pll_input_select = insel_q;
	assign pll_cfg.feedback_divider = fbdiv_q;
	assign pll_cfg.vco_range_select = vco_q;
	assign pll_cfg.output_divider_value = output_divider_value_q;
	assign pll_cfg.vco_bypass_select = byp_q;
	assign pll_cfg.freerun = freerun_q;

	// ======================================================================
	// Read path
	// ======================================================================
	logic [7:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			ADDR_OSC: rd_mux = {4'h0, too_slow_q, 1'b0, insel_q};
			ADDR_SYN: rd_mux = {output_divider_value_q, freerun_q, vco_q, byp_q, 1'b0,
				stable_q};
			ADDR_FBDIV: rd_mux = fbdiv_q;
			ADDR_SYS: rd_mux = {4'h0, fac_q, src_q};
			ADDR_PMC: rd_mux = {4'h0, sd_div_q, sd_en_q};
			ADDR_TEN: rd_mux = {6'h00, lock_en_q, mon_en_q};
			ADDR_TST: rd_mux = {6'h00, lock_flag_q, mon_flag_q};
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) reg_rdata <= 8'h00;
		else reg_rdata <= reg_rd ? rd_mux : 8'h00;
	end

	// ======================================================================
	// Checks
	// ======================================================================
	sequence seq_fr_event;
		lock_loss && !byp_q;
	endsequence
	sequence seq_fr_hold;
		freerun_q && !byp_wr1;
	endsequence

	ref_tick_period_a: assert property (@(posedge clock) disable iff (!nrst)
		ref_tick |-> ##20 ref_tick)
		else $error("reference tick period wrong");
	slow_flag_set_a: assert property (@(posedge clock) disable iff (!nrst)
		win_end && slow_now && !mon_restart |=> too_slow_q)
		else $error("too slow flag not set");
	mon_trap_case_a: assert property (@(posedge clock) disable iff (!nrst)
		$rose(mon_flag_q) |-> $past(slow_rise) && $past(mon_case))
		else $error("monitor trap outside allowed case");
	lock_quiet_a: assert property (@(posedge clock) disable iff (!nrst)
		lock_loss && !pll_used |=> !stable_q && !$rose(lock_flag_q))
		else $error("quiet lock loss misbehaved");
	lock_trap_set_a: assert property (@(posedge clock) disable iff (!nrst)
		lock_loss && pll_used && ever_locked_q |=> lock_flag_q && !stable_q)
		else $error("lock trap flag not set");
	no_early_trap_a: assert property (@(posedge clock) disable iff (!nrst)
		!ever_locked_q |-> !lock_flag_q)
		else $error("lock trap before first lock");
	freerun_force_a: assert property (@(posedge clock) disable iff (!nrst)
		seq_fr_event or seq_fr_hold |=> freerun_q)
		else $error("freerun not held");
	sys_spacing_a: assert property (@(posedge clock) disable iff (!nrst)
		clk_en.sys |=> !clk_en.sys [*2])
		else $error("system clock above limit");
	wake_hold_a: assert property (@(posedge clock) disable iff (!nrst)
		pa_hold_q || power_down |-> !clk_en.periph_a)
		else $error("peripheral a clock early");
	cpu_under_nvm_a: assert property (@(posedge clock) disable iff (!nrst)
		clk_en.cpu |-> clk_en.nvm_access && clk_en.sys)
		else $error("cpu tick without nvm tick");
	sd_off_a: assert property (@(posedge clock) disable iff (!nrst)
		clk_en.sys && !sd_en_q |-> clk_en.nvm_access)
		else $error("slowdown acting while disabled");
	boot_source_a: assert property (@(posedge clock) disable iff (!nrst)
		st_q == ST_BOOT && !stable_q |=> src_q == PSCS_SRC_LP)
		else $error("source left slow clock without lock");
	lock_restart_a: assert property (@(posedge clock) disable iff (!nrst)
		restart_stability_detect |=> !stable_q [*2])
		else $error("stable flag not cleared by restart");

endmodule

// ### testbench/pscs_tb_top.sv
`timescale 1ns/1ns
module pscs_tb_top
	import pscs_pkg::*;
;
	// ==================================================================
	// Signals and the register model
	// ==================================================================
	logic clock, nrst, reg_wr, reg_rd, osc_in, pll_tick, lp_tick;
	logic pll_match, power_down, sysclk_source_q, mon_trap_req;
	logic lock_trap_req, lk1, chk_clk, chk_pa, src_tick;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [31:0] seed;
	pscs_pll_cfg_t pll_cfg;
	pscs_clk_en_t clk_en;
	int num_errors, comparisons, tk, osc_per, s, na, c, pa;
	logic [7:0] m [0:7];
	logic [7:0] wm [0:7] = '{8'h03, 8'hec, 8'hff, 8'h0f, 8'h0f, 8'h03,
		8'h00, 8'h00};

	pscs_top uut (
		.clock(clock),
		.nrst(nrst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.osc_in(osc_in),
		.pll_tick(pll_tick),
		.lp_tick(lp_tick),
		.pll_match(pll_match),
		.power_down(power_down),
		.pll_cfg(pll_cfg),
		.clk_en(clk_en),
		.sysclk_source_q(sysclk_source_q),
		.mon_trap_req(mon_trap_req),
		.lock_trap_req(lock_trap_req)
	);

	// ==================================================================
	// Clock, source ticks and crystal
	// ==================================================================
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// A crystal period of zero stops the crystal, which is how a
	// too-slow input is made without waiting for a real slow clock.
	always @(posedge clock) begin
		tk <= tk + 1;
		pll_tick <= (tk % 4 == 0);
		lp_tick <= (tk % 16 == 0);
		if (osc_per != 0 && tk % osc_per == 0)
			osc_in <= ~osc_in;
	end

	assign src_tick = (m[3][1:0] == 2'h1) ? pll_tick : lp_tick;

	always @(negedge clock) begin
		if (chk_clk) begin
			chk("sys", 16'(src_tick), 16'(clk_en.sys));
			chk("pb", 16'(clk_en.cpu), 16'(clk_en.periph_b));
			chk("nvmb", 16'(clk_en.cpu), 16'(clk_en.nvm_bus));
			if (chk_pa)
				chk("pa", 16'(clk_en.cpu), 16'(clk_en.periph_a));
		end
	end

	// ==================================================================
	// Tasks
	// ==================================================================
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask

	task summarize;
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task mreset;
		for (int j = 0; j < 8; j++)
			m[j] = 8'h00;
		m[1] = {RST_OUTPUT_DIVIDER_VALUE, 5'h00};
		m[2] = RST_FBDIV;
		lk1 = 1'b0;
	endtask

	// Ends on the falling edge so that checks see settled outputs.
	task cyc(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		d = reg_rdata;
	endtask

	task wr(input logic [7:0] a, input logic [7:0] v);
		logic [7:0] k;
		k = wm[a[2:0]];
		if (a == 8'h03 && !lk1)
			k = k & 8'hfc;
		if (a == 8'h06)
			m[6] = m[6] & ~v;
		else if (a < 8'h08)
			m[a[2:0]] = (m[a[2:0]] & ~k) | (v & k);
		if (a == 8'h01 && v[2])
			m[1][4] = 1'b0;
		if (a == 8'h01 && v[1])
			m[1][0] = 1'b0;
		if (a == 8'h00 && v[2])
			m[0][3] = 1'b0;
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(negedge clock);
	endtask

	task rdc(input logic [7:0] a);
		logic [7:0] d;
		rd(a, d);
		chk($sformatf("reg%0h", a), 16'(m[a[2:0]]), 16'(d));
	endtask

	task wb(input logic [7:0] a, input int b, input logic v);
		logic [7:0] d;
		for (int j = 0; j < 1500; j++) begin
			rd(a, d);
			if (d[b] === v)
				break;
		end
		chk($sformatf("bit%0h_%0d", a, b), 16'(v), 16'(d[b]));
	endtask

	task relock;
		wr(8'h01, m[1] | 8'h02);
		rdc(8'h01);
		wb(8'h01, 0, 1'b1);
		m[1][0] = 1'b1;
		wr(8'h01, m[1] & 8'hfb);
		rdc(8'h01);
	endtask

	task cnt(input int n);
		s = 0;
		na = 0;
		c = 0;
		pa = 0;
		repeat (n) begin
			@(negedge clock);
			s += int'(clk_en.sys);
			na += int'(clk_en.nvm_access);
			c += int'(clk_en.cpu);
			pa += int'(clk_en.periph_a);
		end
	endtask

	// ==================================================================
	// Sequence
	// ==================================================================
	initial begin
		repeat (40000) @(posedge clock);
		num_errors++;
		summarize();
	end

	initial begin
		nrst = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		osc_in = 1'b0;
		pll_tick = 1'b0;
		lp_tick = 1'b0;
		pll_match = 1'b0;
		power_down = 1'b0;
		tk = 0;
		osc_per = 10;
		chk_clk = 1'b0;
		chk_pa = 1'b0;
		seed = 32'h96cb;
		num_errors = 0;
		comparisons = 0;
		mreset();
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		for (int j = 0; j < 8; j++)
			rdc(8'(j));
		chk("cfg", 16'({2'h0, 8'h10, 1'b0, 3'h2, 1'b0, 1'b0}),
			16'(pll_cfg));
		wr(8'h03, 8'h01);
		rdc(8'h03);
		chk("src", 16'h0, 16'(sysclk_source_q));
		@(posedge clock) pll_match <= 1'b1;
		wb(8'h01, 0, 1'b1);
		m[1][0] = 1'b1;
		m[3][1:0] = 2'h1;
		lk1 = 1'b1;
		cyc(3);
		chk("src", 16'h1, 16'(sysclk_source_q));
		rdc(8'h03);
		chk_clk = 1'b1;
		chk_pa = 1'b1;
		wr(8'h05, 8'h03);
		wr(8'h01, m[1] | 8'h04);
		wr(8'h01, m[1] | 8'h08);
		for (int j = 0; j < 4; j++) begin
			seed = xs(seed);
			wr(8'h02, seed[7:0]);
			rdc(8'h02);
			chk("fbdiv", 16'(seed[7:0]), 16'(pll_cfg.feedback_divider));
		end
		relock();
		@(posedge clock) pll_match <= 1'b0;
		cyc(3);
		m[1] = (m[1] & 8'hfe) | 8'h10;
		m[6][1] = 1'b1;
		rdc(8'h01);
		rdc(8'h06);
		chk("ltrap", 16'h1, 16'(lock_trap_req));
		chk("frun", 16'h1, 16'(pll_cfg.freerun));
		wr(8'h05, 8'h01);
		chk("ltrap", 16'h0, 16'(lock_trap_req));
		wr(8'h05, 8'h03);
		@(posedge clock) pll_match <= 1'b1;
		wr(8'h01, m[1] | 8'h04);
		rdc(8'h01);
		relock();
		wr(8'h06, 8'h02);
		rdc(8'h06);
		chk("ltrap", 16'h0, 16'(lock_trap_req));
		wr(8'h01, m[1] | 8'h04);
		@(posedge clock) pll_match <= 1'b0;
		cyc(3);
		m[1][0] = 1'b0;
		rdc(8'h01);
		rdc(8'h06);
		chk("ltrap", 16'h0, 16'(lock_trap_req));
		@(posedge clock) pll_match <= 1'b1;
		// A steady match relocks on its own, without a restart.
		wb(8'h01, 0, 1'b1);
		m[1][0] = 1'b1;
		wr(8'h00, 8'h01);
		chk("insel", 16'(INSEL_XTAL), 16'(pll_cfg.pll_input_select));
		osc_per = 0;
		wb(8'h00, 3, 1'b1);
		cyc(2);
		m[0][3] = 1'b1;
		m[6][0] = 1'b1;
		m[1][4] = 1'b1;
		rdc(8'h06);
		rdc(8'h01);
		chk("mtrap", 16'h1, 16'(mon_trap_req));
		osc_per = 10;
		wr(8'h00, m[0] | 8'h04);
		rdc(8'h00);
		cyc(1100);
		rdc(8'h00);
		wr(8'h01, m[1] | 8'h04);
		relock();
		wr(8'h06, 8'h01);
		rdc(8'h06);
		chk("mtrap", 16'h0, 16'(mon_trap_req));
		osc_per = 0;
		wb(8'h00, 3, 1'b1);
		cyc(2);
		m[0][3] = 1'b1;
		rdc(8'h06);
		rdc(8'h01);
		osc_per = 10;
		wr(8'h00, m[0] | 8'h04);
		cnt(400);
		chk("nvm", 16'(s), 16'(na));
		chk("cpu", 16'(na), 16'(c));
		wr(8'h03, m[3] | 8'h04);
		cnt(400);
		chk("fac", 16'h1, 16'(2 * c - na <= 2 && na - 2 * c <= 2));
		wr(8'h04, 8'h02);
		rdc(8'h04);
		cnt(400);
		chk("sd_off", 16'(s), 16'(na));
		wr(8'h04, 8'h03);
		cnt(400);
		chk("sd_on", 16'h1, 16'(2 * na - s <= 2 && s - 2 * na <= 2));
		wr(8'h04, 8'h00);
		wr(8'h03, m[3] & 8'hf3);
		// A stopped crystal that drives the system clock traps even with
		// bypass off, but must not force freerun.
		chk_clk = 1'b0;
		wr(8'h03, 8'h02);
		osc_per = 0;
		wb(8'h00, 3, 1'b1);
		cyc(2);
		m[0][3] = 1'b1;
		m[6][0] = 1'b1;
		rdc(8'h06);
		rdc(8'h01);
		chk("mtrap", 16'h1, 16'(mon_trap_req));
		osc_per = 10;
		wr(8'h03, 8'h01);
		wr(8'h00, m[0] | 8'h04);
		wr(8'h06, 8'h01);
		rdc(8'h06);
		rdc(8'h00);
		// Peripheral clock a must wait for lock after a wake-up.
		chk_clk = 1'b0;
		chk_pa = 1'b0;
		@(posedge clock) power_down <= 1'b1;
		wr(8'h01, m[1] | 8'h04);
		@(posedge clock) pll_match <= 1'b0;
		cyc(3);
		m[1][0] = 1'b0;
		@(posedge clock) power_down <= 1'b0;
		chk_clk = 1'b1;
		cnt(100);
		chk("pa_off", 16'h0, 16'(pa));
		chk("cpu_on", 16'h1, 16'(c > 0));
		@(posedge clock) pll_match <= 1'b1;
		wb(8'h01, 0, 1'b1);
		m[1][0] = 1'b1;
		cyc(4);
		chk_pa = 1'b1;
		cnt(100);
		chk("pa_on", 16'(c), 16'(pa));
		wr(8'h01, m[1] & 8'hfb);
		// A second reset: no lock trap before the first lock.
		chk_clk = 1'b0;
		@(posedge clock) nrst <= 1'b0;
		cyc(6);
		mreset();
		@(posedge clock) nrst <= 1'b1;
		wr(8'h05, 8'h03);
		@(posedge clock) pll_match <= 1'b1;
		cyc(50);
		@(posedge clock) pll_match <= 1'b0;
		cyc(3);
		rdc(8'h06);
		chk("ltrap", 16'h0, 16'(lock_trap_req));
		rdc(8'h03);
		chk("src", 16'h0, 16'(sysclk_source_q));
		summarize();
	end
endmodule
